/* File: include/nbmt_defs.svh */
`ifndef NBMT_DEFS_SVH
`define NBMT_DEFS_SVH

// Start codes, sampled on the last clock of a low frame strobe.
`define NBMT_START_READ  4'hD
`define NBMT_START_WRITE 4'hE

// Handshake codes driven by the target.
`define NBMT_SYNC_READY  4'h0
`define NBMT_SYNC_WAIT   4'h5

// Turnaround drive value and the only legal size code.
`define NBMT_TAR_ONES    4'hF
`define NBMT_SIZE_BYTE   4'h0

// Address nibbles are counted 0 to 6.
`define NBMT_ADDR_LAST   3'h6

// Address bit that steers an access to the memory core (1) or register space (0).
`define NBMT_CORE_BIT    22

// Master accepts this many wait handshakes and gives up on the next one.
`define NBMT_SYNC_LIMIT  5'h1F

// Reset values of the idle bus drive.
`define NBMT_OE_RESET    1'h0
`define NBMT_DOUT_RESET  4'hF

`endif

/* File: include/nbmt_pkg.sv */
package nbmt_pkg;

  typedef enum logic [11:0] {
    TGT_IDLE  = 12'h001,
    TGT_START = 12'h002,
    TGT_ADDR  = 12'h004,
    TGT_SIZE  = 12'h008,
    TGT_WLO   = 12'h010,
    TGT_WHI   = 12'h020,
    TGT_TURNAROUND_FIRST_CLOCK  = 12'h040,
    TGT_TURNAROUND_SECOND_CLOCK  = 12'h080,
    TGT_SYNC  = 12'h100,
    TGT_DLO   = 12'h200,
    TGT_DHI   = 12'h400,
    TGT_TTAR  = 12'h800
  } nbmt_tgt_e;

  typedef struct packed {
    nbmt_tgt_e   st;
    logic [3:0]  start;
    logic        write;
    logic [2:0]  cnt;
    logic [27:0] addr;
    logic [7:0]  wdata;
    logic [7:0]  rdata;
    logic        ready;
    logic        req;
    logic        oe;
    logic [3:0]  dout;
  } nbmt_tgt_s;

  typedef enum logic [13:0] {
    MST_IDLE  = 14'h0001,
    MST_START = 14'h0002,
    MST_DEVICE_SELECT_FIELD = 14'h0004,
    MST_ADDR  = 14'h0008,
    MST_SIZE  = 14'h0010,
    MST_WLO   = 14'h0020,
    MST_WHI   = 14'h0040,
    MST_TURNAROUND_FIRST_CLOCK  = 14'h0080,
    MST_TURNAROUND_SECOND_CLOCK  = 14'h0100,
    MST_SYNC  = 14'h0200,
    MST_RLO   = 14'h0400,
    MST_RHI   = 14'h0800,
    MST_TTAR0 = 14'h1000,
    MST_TTAR1 = 14'h2000
  } nbmt_mst_e;

  typedef struct packed {
    nbmt_mst_e   st;
    logic        write;
    logic [3:0]  sel;
    logic [27:0] addr;
    logic [7:0]  wdata;
    logic [2:0]  cnt;
    logic [4:0]  waits;
    logic        frame_n;
    logic        oe;
    logic [3:0]  dout;
    logic [7:0]  rdata;
    logic        rsp_valid;
    logic        rsp_timeout;
  } nbmt_mst_s;

endpackage

/* File: include/nbmt_if.sv */
`timescale 1ns/1ps

interface nbmt_if;
  logic       cycle_frame_strobe_n;
  logic [3:0] mst_dout;
  logic       mst_oe;
  logic [3:0] tgt_dout;
  logic       tgt_oe;
  logic [3:0] multiplexed_nibble_lines;

  // Resolved lines; an undriven bus reads as pulled-up ones.
  assign multiplexed_nibble_lines = tgt_oe ? tgt_dout : (mst_oe ? mst_dout : 4'hF);

  modport master (
    output cycle_frame_strobe_n,
    output mst_dout,
    output mst_oe,
    input  multiplexed_nibble_lines
  );

  modport target (
    input  cycle_frame_strobe_n,
    output tgt_dout,
    output tgt_oe,
    input  multiplexed_nibble_lines
  );
endinterface

/* File: logic/nbmt_master.sv */
`timescale 1ns/1ps
`include "nbmt_defs.svh"

module nbmt_master
  import nbmt_pkg::*;
(
  // Clock and reset.
  input  wire logic        clk,
  input  wire logic        reset,
  // Bus.
  nbmt_if.master           bus,
  // Command.
  input  wire logic        cmd_valid,
  input  wire logic        cmd_write,
  input  wire logic [3:0]  cmd_sel,
  input  wire logic [27:0] cmd_addr,
  input  wire logic [7:0]  cmd_wdata,
  output logic             cmd_ready,
  // Response.
  output logic             rsp_valid,
  output logic             rsp_timeout,
  output logic [7:0]       rsp_rdata
);

  nbmt_mst_s s_r;
  nbmt_mst_s s_nxt;
  logic [3:0] lanes;

  assign lanes = bus.multiplexed_nibble_lines;

  always_comb begin
    s_nxt = s_r;
    s_nxt.rsp_valid = 1'b0;
    s_nxt.frame_n = 1'b1;
    unique case (s_r.st)
      MST_IDLE: begin
        if (cmd_valid) begin
          s_nxt.st = MST_START;
          s_nxt.write = cmd_write;
          s_nxt.sel = cmd_sel;
          s_nxt.addr = cmd_addr;
          s_nxt.wdata = cmd_wdata;
          s_nxt.rsp_timeout = 1'b0;
          s_nxt.frame_n = 1'b0; // [R6]
          s_nxt.oe = 1'b1;
          s_nxt.dout = cmd_write ? `NBMT_START_WRITE : `NBMT_START_READ; // [R16]
        end
      end
      MST_START: begin
        s_nxt.st = MST_DEVICE_SELECT_FIELD;
        s_nxt.dout = s_r.sel;
      end
      MST_DEVICE_SELECT_FIELD: begin
        s_nxt.st = MST_ADDR;
        s_nxt.cnt = 3'h0;
        s_nxt.dout = s_r.addr[27:24]; // [R8]
        s_nxt.addr = {s_r.addr[23:0], 4'h0};
      end
      MST_ADDR: begin
        s_nxt.cnt = s_r.cnt + 3'h1;
        if (s_r.cnt == `NBMT_ADDR_LAST) begin
          s_nxt.st = MST_SIZE;
          s_nxt.dout = `NBMT_SIZE_BYTE; // [R9]
        end else begin
          s_nxt.dout = s_r.addr[27:24]; // [R8]
          s_nxt.addr = {s_r.addr[23:0], 4'h0};
        end
      end
      MST_SIZE: begin
        if (s_r.write) begin
          s_nxt.st = MST_WLO;
          s_nxt.dout = s_r.wdata[3:0]; // [R15]
        end else begin
          s_nxt.st = MST_TURNAROUND_FIRST_CLOCK;
          s_nxt.dout = `NBMT_TAR_ONES; // [R3]
        end
      end
      MST_WLO: begin
        s_nxt.st = MST_WHI;
        s_nxt.dout = s_r.wdata[7:4]; // [R15]
      end
      MST_WHI: begin
        s_nxt.st = MST_TURNAROUND_FIRST_CLOCK;
        s_nxt.dout = `NBMT_TAR_ONES; // [R3]
      end
      MST_TURNAROUND_FIRST_CLOCK: begin
        s_nxt.st = MST_TURNAROUND_SECOND_CLOCK;
        s_nxt.oe = 1'b0; // [R3]
      end
      MST_TURNAROUND_SECOND_CLOCK: begin
        s_nxt.st = MST_SYNC;
        s_nxt.waits = 5'h0;
      end
      MST_SYNC: begin
        if (lanes == `NBMT_SYNC_READY) begin // [R18]
          s_nxt.st = s_r.write ? MST_TTAR0 : MST_RLO;
        end else if (lanes == `NBMT_SYNC_WAIT && s_r.waits != `NBMT_SYNC_LIMIT) begin
          s_nxt.waits = s_r.waits + 5'h1;
        end else begin
          // A strobe pulse aborts the cycle and frees a stuck target.
          s_nxt.st = MST_IDLE;
          s_nxt.frame_n = 1'b0;
          s_nxt.rsp_valid = 1'b1;
          s_nxt.rsp_timeout = 1'b1;
        end
      end
      MST_RLO: begin
        s_nxt.st = MST_RHI;
        s_nxt.rdata[3:0] = lanes; // [R2]
      end
      MST_RHI: begin
        s_nxt.st = MST_TTAR0;
        s_nxt.rdata[7:4] = lanes; // [R2]
      end
      MST_TTAR0: begin
        s_nxt.st = MST_TTAR1;
      end
      MST_TTAR1: begin
        s_nxt.st = MST_IDLE;
        s_nxt.rsp_valid = 1'b1;
      end
    endcase
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      s_r <= '{st: MST_IDLE, write: 1'b0, sel: 4'h0, addr: 28'h0, wdata: 8'h0, cnt: 3'h0, waits: 5'h0,
               frame_n: 1'b1, oe: `NBMT_OE_RESET, dout: `NBMT_DOUT_RESET, rdata: 8'h0,
               rsp_valid: 1'b0, rsp_timeout: 1'b0};
    end else begin
      s_r <= s_nxt;
    end
  end

  assign bus.cycle_frame_strobe_n = s_r.frame_n;
  assign bus.mst_oe = s_r.oe;
  assign bus.mst_dout = s_r.dout;
  assign cmd_ready = (s_r.st == MST_IDLE);
  assign rsp_valid = s_r.rsp_valid;
  assign rsp_timeout = s_r.rsp_timeout;
  assign rsp_rdata = s_r.rdata;

endmodule // nbmt_master

/* File: logic/nbmt_target.sv */
`timescale 1ns/1ps
`include "nbmt_defs.svh"

// Behaviour
// [R1] Read: after master turnaround, target drives handshakes.
// [R2] Read data low nibble, high nibble, turnaround.
// [R3] Handover: ones one clock, then float.
// [R4] Repeat wait code, then ready when data.
// [R5] Only ready 0000 and wait 0101 used.
// [R6] Master opens; last start nibble counts.
// [R7] Respond only when select matches strapped pins.
// [R8] Address: seven nibbles, most significant first.
// [R9] Size nibble zero: single byte.
// [R10] Wait count follows internal access time.
// [R11] Ready exactly one clock before low data.
// [R12] Ones after data, then float.
// [R13] Reset release returns to array-read idle.
// [R14] Reads reach array, identifiers, locks, inputs.
// [R15] Write: data low, high, then turnaround.
// [R16] Writes share preamble; single-byte writes supported.
// [R17] Write: take bus, handshake, hand back.
// [R18] Fields valid and sampled at rising edge.
// [R19] Access starts when address phase completes.
// [R20] Strobe low: release lines next clock.
// [R21] Write acknowledged with ready on clock 15.
// [R22] Unselected target keeps lines floating.

module nbmt_target
  import nbmt_pkg::*;
(
  // Clock and reset.
  input  wire logic        clk,
  input  wire logic        reset,
  // Bus.
  nbmt_if.target           bus,
  // Strapped device select.
  input  wire logic [3:0]  strapped_select_pins,
  // Access request to the storage behind the target.
  output logic             acc_req,
  output logic             acc_write,
  output logic             acc_core,
  output logic [27:0]      acc_addr,
  output logic [7:0]       acc_wdata,
  // Access completion.
  input  wire logic        acc_done,
  input  wire logic [7:0]  acc_rdata,
  // Status.
  output logic             busy
);

  nbmt_tgt_s  s_r;
  nbmt_tgt_s  s_nxt;
  logic [3:0] lanes;
  logic       frame_low;
  logic       data_ready;
  logic       sel_hit;

  assign lanes = bus.multiplexed_nibble_lines;
  assign frame_low = ~bus.cycle_frame_strobe_n;

  // Only memory read and memory write start codes are decoded by this target.
  function automatic logic start_known(input logic [3:0] code);
    start_known = (code == `NBMT_START_READ) || (code == `NBMT_START_WRITE);
  endfunction

  // A cycle is ours only for a known start code and a select field that matches the straps.
  assign sel_hit = start_known(s_r.start) && (lanes == strapped_select_pins);

  // Next-state logic of the whole target; a low frame strobe takes priority over every state.
  always_comb begin
    s_nxt = s_r;
    s_nxt.req = 1'b0;
    // Read data is captured whenever the storage answers a read.
    if (acc_done && !s_r.write) begin
      s_nxt.rdata = acc_rdata;
      s_nxt.ready = 1'b1;
    end
    // Data counts as ready in the very cycle the storage answers, so no clock is lost.
    data_ready = s_r.ready | (acc_done & ~s_r.write);
    if (frame_low) begin
      // Any low strobe restarts decoding and aborts a running cycle.
      // A store already launched is not cancelled; the storage finishes it on its own.
      s_nxt.st = TGT_START;
      s_nxt.start = lanes; // [R6]
      s_nxt.oe = 1'b0; // [R20]
    end else begin
      unique case (s_r.st)
        TGT_IDLE: begin
          // Unselected, the lines stay released and the drive value rests at ones.
          s_nxt.oe = 1'b0; // [R22]
          s_nxt.dout = `NBMT_DOUT_RESET;
        end
        TGT_START: begin
          // The nibble now on the lines is the select field.
          if (sel_hit) begin // [R7]
            s_nxt.st = TGT_ADDR;
            s_nxt.write = (s_r.start == `NBMT_START_WRITE); // [R16]
            s_nxt.cnt = 3'h0;
          end else begin
            s_nxt.st = TGT_IDLE;
          end
        end
        TGT_ADDR: begin
          // Shifting in from the bottom leaves the first nibble in the top bits.
          s_nxt.addr = {s_r.addr[23:0], lanes}; // [R8] [R18]
          s_nxt.cnt = s_r.cnt + 3'h1;
          if (s_r.cnt == `NBMT_ADDR_LAST) begin
            s_nxt.st = TGT_SIZE;
          end
        end
        TGT_SIZE: begin
          if (lanes != `NBMT_SIZE_BYTE) begin // [R9]
            s_nxt.st = TGT_IDLE;
          end else if (s_r.write) begin
            s_nxt.st = TGT_WLO;
          end else begin
            // Turnaround clocks count toward the access time.
            s_nxt.st = TGT_TURNAROUND_FIRST_CLOCK;
            s_nxt.req = 1'b1; // [R19] [R14]
            s_nxt.ready = 1'b0;
          end
        end
        TGT_WLO: begin
          s_nxt.st = TGT_WHI;
          s_nxt.wdata[3:0] = lanes; // [R15]
        end
        TGT_WHI: begin
          // The store is launched only after the last nibble arrived.
          s_nxt.st = TGT_TURNAROUND_FIRST_CLOCK;
          s_nxt.wdata[7:4] = lanes; // [R15]
          s_nxt.req = 1'b1; // [R16]
        end
        TGT_TURNAROUND_FIRST_CLOCK: begin
          s_nxt.st = TGT_TURNAROUND_SECOND_CLOCK;
        end
        TGT_TURNAROUND_SECOND_CLOCK: begin
          s_nxt.st = TGT_SYNC;
          s_nxt.oe = 1'b1; // [R1] [R17]
          if (s_r.write || data_ready) begin
            s_nxt.dout = `NBMT_SYNC_READY; // [R21] [R5]
          end else begin
            s_nxt.dout = `NBMT_SYNC_WAIT; // [R4] [R5]
          end
        end
        TGT_SYNC: begin
          // A ready code is followed by read data, or by the handback on a write.
          if (s_r.dout == `NBMT_SYNC_READY) begin
            if (s_r.write) begin
              s_nxt.st = TGT_TTAR;
              s_nxt.dout = `NBMT_TAR_ONES; // [R17] [R3]
            end else begin
              s_nxt.st = TGT_DLO;
              s_nxt.dout = s_r.rdata[3:0]; // [R11] [R2]
            end
          end else if (data_ready) begin
            s_nxt.dout = `NBMT_SYNC_READY; // [R4] [R10]
          end else begin
            s_nxt.dout = `NBMT_SYNC_WAIT; // [R4] [R10]
          end
        end
        TGT_DLO: begin
          s_nxt.st = TGT_DHI;
          s_nxt.dout = s_r.rdata[7:4]; // [R2]
        end
        TGT_DHI: begin
          s_nxt.st = TGT_TTAR;
          s_nxt.dout = `NBMT_TAR_ONES; // [R12] [R3]
        end
        TGT_TTAR: begin
          // Released lines read as ones through the pull-up until the master drives.
          s_nxt.st = TGT_IDLE;
          s_nxt.oe = 1'b0; // [R12] [R3]
          s_nxt.dout = `NBMT_DOUT_RESET;
        end
      endcase
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      // Idle with lines released is the array-read state.
      s_r <= '{st:    TGT_IDLE,
               start: 4'h0,
               write: 1'b0,
               cnt:   3'h0,
               addr:  28'h0,
               wdata: 8'h0,
               rdata: 8'h0,
               ready: 1'b0,
               req:   1'b0,
               oe:    `NBMT_OE_RESET,
               dout:  `NBMT_DOUT_RESET}; // [R13]
    end else begin
      s_r <= s_nxt;
    end
  end

  // Bus drive and storage request come straight from the state register.
  assign bus.tgt_oe = s_r.oe;
  assign bus.tgt_dout = s_r.dout;
  assign acc_req = s_r.req;
  assign acc_write = s_r.write;
  assign acc_addr = s_r.addr;
  assign acc_core = s_r.addr[`NBMT_CORE_BIT]; // [R14]
  assign acc_wdata = s_r.wdata;
  assign busy = (s_r.st != TGT_IDLE);

endmodule // nbmt_target

/* File: verification/nbmt_asserts.sv */
`timescale 1ns/1ps

module nbmt_asserts (
  // Clock and reset.
  input wire logic       clk,
  input wire logic       reset,
  // Bus signals.
  input wire logic       cycle_frame_strobe_n,
  input wire logic [3:0] mst_dout,
  input wire logic       mst_oe,
  input wire logic [3:0] tgt_dout,
  input wire logic       tgt_oe,
  input wire logic [3:0] multiplexed_nibble_lines
);
  // Last start nibble seen, and whether the target is still in its handshake phase.
  logic [3:0] start_r;
  logic       hs_r;
  wire        rd  = start_r == 4'hD;
  wire        wr  = start_r == 4'hE;
  wire        rdy = tgt_oe && hs_r && tgt_dout == 4'h0;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      start_r <= 4'hF;
      hs_r    <= 1'b1;
    end else begin
      if (!cycle_frame_strobe_n) begin
        start_r <= multiplexed_nibble_lines;
      end
      hs_r <= !tgt_oe || (hs_r && tgt_dout == 4'h5);
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  property p_hs_codes;
    tgt_oe && hs_r |-> tgt_dout inside {4'h0, 4'h5};
  endproperty
  a_hs_codes: assert property (p_hs_codes) else $error("bad handshake code");
  property p_read_take;
    $rose(tgt_oe) && rd |-> $past(cycle_frame_strobe_n, 11) && !$past(cycle_frame_strobe_n, 12);
  endproperty
  a_read_take: assert property (p_read_take) else $error("read bus taken late");
  property p_write_take;
    $rose(tgt_oe) && wr |-> tgt_dout == 4'h0 && $past(cycle_frame_strobe_n, 13) && !$past(cycle_frame_strobe_n, 14);
  endproperty
  a_write_take: assert property (p_write_take) else $error("write ack misplaced");
  property p_read_tail;
    rdy && rd |=> tgt_oe ##1 tgt_oe ##1 (tgt_oe && tgt_dout == 4'hF) ##1 !tgt_oe;
  endproperty
  a_read_tail: assert property (p_read_tail) else $error("read data phase wrong");
  property p_write_tail;
    rdy && wr |=> (tgt_oe && tgt_dout == 4'hF) ##1 !tgt_oe;
  endproperty
  a_write_tail: assert property (p_write_tail) else $error("write handback wrong");
  property p_tgt_hand;
    $fell(tgt_oe) && $past(cycle_frame_strobe_n) |-> $past(tgt_dout) == 4'hF;
  endproperty
  a_tgt_hand: assert property (p_tgt_hand) else $error("target float without ones");
  property p_mst_hand;
    $fell(mst_oe) && cycle_frame_strobe_n |-> $past(mst_dout) == 4'hF;
  endproperty
  a_mst_hand: assert property (p_mst_hand) else $error("master float without ones");
  property p_float_gap;
    $rose(tgt_oe) |-> !$past(mst_oe);
  endproperty
  a_float_gap: assert property (p_float_gap) else $error("no float clock");
  property p_release;
    !cycle_frame_strobe_n |=> !tgt_oe;
  endproperty
  a_release: assert property (p_release) else $error("drive after strobe");
endmodule // nbmt_asserts

/* File: verification/testbench.sv */
`timescale 1ns/1ps

module testbench;
  logic        clk, reset, cmd_valid, cmd_write, cmd_ready, rsp_valid, rsp_timeout;
  logic [3:0]  cmd_sel, strapped_select_pins, p;
  logic [27:0] cmd_addr, acc_addr;
  logic [7:0]  cmd_wdata, rsp_rdata, acc_wdata, acc_rdata;
  logic        acc_req, acc_write, acc_core, acc_done, busy, sy;
  int          fails, num_checks, dly, cnt, waits, reqs;

  nbmt_if bus ();
  nbmt_master u_nbmt_master (.clk(clk), .reset(reset), .bus(bus), .cmd_valid(cmd_valid),
    .cmd_write(cmd_write), .cmd_sel(cmd_sel), .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata),
    .cmd_ready(cmd_ready), .rsp_valid(rsp_valid), .rsp_timeout(rsp_timeout), .rsp_rdata(rsp_rdata));
  nbmt_target u_nbmt_target (.clk(clk), .reset(reset), .bus(bus),
    .strapped_select_pins(strapped_select_pins), .acc_req(acc_req), .acc_write(acc_write),
    .acc_core(acc_core), .acc_addr(acc_addr), .acc_wdata(acc_wdata), .acc_done(acc_done),
    .acc_rdata(acc_rdata), .busy(busy));
  nbmt_asserts u_chk (.clk(clk), .reset(reset), .cycle_frame_strobe_n(bus.cycle_frame_strobe_n),
    .mst_dout(bus.mst_dout), .mst_oe(bus.mst_oe), .tgt_dout(bus.tgt_dout), .tgt_oe(bus.tgt_oe),
    .multiplexed_nibble_lines(bus.multiplexed_nibble_lines));

  function automatic logic [7:0] mem_byte(input logic [27:0] a);
    return a[7:0] ^ a[19:12] ^ 8'h3C;
  endfunction

  // Storage answers dly cycles after each request; wait codes before the first ready are counted.
  always @(posedge clk) begin
    if (acc_req) begin
      reqs <= reqs + 1;
      cnt <= dly - 1;
      acc_done <= (dly == 1);
      acc_rdata <= mem_byte(acc_addr);
    end else begin
      acc_done <= (cnt == 1);
      if (cnt != 0) cnt <= cnt - 1;
    end
    sy <= bus.tgt_oe && (sy || bus.tgt_dout == 4'h0);
    if (bus.tgt_oe && !sy && bus.tgt_dout == 4'h5) waits <= waits + 1;
  end

  task automatic check(input logic ok, input string what);
    num_checks++;
    if (!ok) begin
      fails++;
      $display("ERROR %0t %s", $time, what);
    end
  endtask

  task automatic conclude();
    if (fails == 0 && num_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic xfer(input logic wr, input logic [3:0] sel, input logic [3:0] pins,
                      input logic [27:0] addr, input int d);
    logic [7:0] wd;
    logic       hit;
    int         n;
    wd = 8'($urandom);
    hit = sel == pins;
    @(posedge clk);
    strapped_select_pins <= pins;
    cmd_valid <= 1'b1;
    cmd_write <= wr;
    cmd_sel <= sel;
    cmd_addr <= addr;
    cmd_wdata <= wd;
    dly <= d;
    waits <= 0;
    reqs <= 0;
    @(posedge clk);
    cmd_valid <= 1'b0;
    n = 0;
    do begin
      @(posedge clk);
      #1;
      n++;
    end while (rsp_valid !== 1'b1 && n < 200);
    check(n < 200, "no response");
    if (n >= 200) conclude();
    check(rsp_timeout === !hit, "timeout flag");
    check(reqs == (hit ? 1 : 0), "access count");
    if (hit) check(acc_addr === addr && acc_write === wr && acc_core === addr[22], "access fields");
    if (hit && wr) check(acc_wdata === wd, "write data");
    if (hit && !wr) check(rsp_rdata === mem_byte(addr), "read data");
    if (hit && !wr) check(waits == (d > 1 ? d - 1 : 0), "wait count");
  endtask

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  initial begin
    reset = 1'b1;
    {cmd_valid, cmd_write, cmd_sel, cmd_addr, cmd_wdata, acc_done, acc_rdata, sy} = '0;
    strapped_select_pins = 4'hA;
    {fails, num_checks, cnt, waits, reqs} = '0;
    dly = 1;
    void'($urandom(32'h5638));
    repeat (3) @(posedge clk);
    reset <= 1'b0;
    xfer(1'b0, 4'hA, 4'hA, 28'hFFFFFFF, 3);
    xfer(1'b0, 4'h0, 4'h0, 28'h0000000, 1);
    xfer(1'b1, 4'hF, 4'hF, 28'h0400000, 9);
    xfer(1'b0, 4'h5, 4'hA, 28'h1234567, 1);
    xfer(1'b1, 4'h3, 4'hC, 28'h7654321, 1);
    for (int i = 0; i < 40; i++) begin
      p = 4'($urandom);
      xfer(1'($urandom), ($urandom_range(3) == 0) ? 4'($urandom) : p, p, 28'($urandom), $urandom_range(9, 1));
    end
    @(posedge clk);
    reset <= 1'b1;
    repeat (3) @(posedge clk);
    reset <= 1'b0;
    xfer(1'b0, 4'h9, 4'h9, 28'h0ABCDEF, 2);
    conclude();
  end
endmodule // testbench
